// ==== rtl/aft_cmd_decoder.sv ====
// Purpose: Decoder for the temperature sense and set-features commands
// Assumes: Host strobes cmd_wr with the command and the other registers already stable
// Notes: Execution takes two cycles, busy shown in between
`timescale 1ns/10ps
module aft_cmd_decoder #(
    parameter int LINK_FEAT_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] feature,
    input wire logic [7:0] sector_count,
    input wire logic [7:0] sector_number,
    input wire logic [7:0] cyl_low,
    input wire logic [7:0] cyl_high,
    input wire logic [7:0] device_head,
    input wire logic signed [10:0] temp_half_deg,
    output logic [7:0] command_error_flags,
    output logic [7:0] command_status_flags,
    output logic [7:0] result_count,
    output logic wcache_en,
    output logic rla_en,
    output logic revert_en,
    output logic release_irq_en,
    output logic apm_en,
    output logic [7:0] apm_level,
    output logic puis_en,
    output logic in_standby,
    output logic spinup_req,
    output logic [LINK_FEAT_W-1:0] link_feat_en,
    output logic [7:0] xfer_mode,
    output logic iordy_off,
    output logic [15:0] pio_sect_time,
    output logic [15:0] dma_sect_time,
    output logic epc_req,
    output logic [7:0] epc_arg
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        AFT_IDLE = 3'b001,
        AFT_EXEC = 3'b010,
        AFT_DONE = 3'b100
    } aft_state_t;

    aft_state_t state_r;
    aft_state_t state_nxt;
    logic [7:0] cmd_r;
    logic [7:0] feat_r;
    logic [7:0] cnt_r;
    logic [7:0] snum_r;
    logic [7:0] cyl_lo_r;
    logic [7:0] cyl_hi_r;
    logic [7:0] dh_r;
    logic abort;
    logic [7:0] temp_code;
    logic [4:0] xf_type;
    logic [2:0] xf_mode;
    logic xf_ok;
    logic apm_ok;
    logic link_ok;
    logic do_sf;

    aft_temp_encode u_temp (
        .temp_half_deg(temp_half_deg),
        .code(temp_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // Capture the task file once, so the host may change it mid-command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_r <= 8'h00;
            feat_r <= 8'h00;
            cnt_r <= 8'h00;
            snum_r <= 8'h00;
            cyl_lo_r <= 8'h00;
            cyl_hi_r <= 8'h00;
            dh_r <= 8'h00;
        end else if (cmd_wr && state_r == AFT_IDLE) begin
            cmd_r <= cmd_code;
            feat_r <= feature;
            cnt_r <= sector_count;
            snum_r <= sector_number;
            cyl_lo_r <= cyl_low;
            cyl_hi_r <= cyl_high;
            dh_r <= device_head;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            AFT_IDLE: begin
                if (cmd_wr) begin
                    state_nxt = AFT_EXEC;
                end
            end
            AFT_EXEC: begin
                state_nxt = AFT_DONE;
            end
            AFT_DONE: begin
                state_nxt = AFT_IDLE;
            end
            default: begin
                state_nxt = AFT_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= AFT_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode and validity
    assign xf_type = cnt_r[7:aft_pkg::XF_TYPE_LSB];
    assign xf_mode = cnt_r[aft_pkg::XF_TYPE_LSB-1:0];

    always_comb begin
        unique case (xf_type)
            aft_pkg::XF_PIO_DEFAULT: xf_ok = xf_mode <= aft_pkg::XF_PIO_DEF_IORDY_OFF;
            aft_pkg::XF_PIO_FLOW: xf_ok = xf_mode <= aft_pkg::XF_PIO_FLOW_MAX;
            aft_pkg::XF_MWDMA: xf_ok = xf_mode <= aft_pkg::XF_MWDMA_MAX;
            aft_pkg::XF_UDMA: xf_ok = xf_mode <= aft_pkg::XF_UDMA_MAX;
            default: xf_ok = 1'b0;
        endcase
    end

    assign apm_ok = cnt_r != aft_pkg::APM_ABORT_LO && cnt_r != aft_pkg::APM_ABORT_HI;
    // Link features beyond the vector width are refused
    assign link_ok = cnt_r != 8'h00 && cnt_r < 8'(LINK_FEAT_W);

    always_comb begin
        abort = 1'b0;
        if (cmd_r == aft_pkg::CMD_TEMP_SENSE) begin
            abort = feat_r != aft_pkg::TEMP_FEATURE_OK;
        end else if (cmd_r == aft_pkg::CMD_SET_FEATURES) begin
            if (!dh_r[aft_pkg::DH_BIT7] || !dh_r[aft_pkg::DH_BIT5]) begin
                abort = 1'b1;
            end else begin
                unique case (feat_r)
                    aft_pkg::SF_WCACHE_ON, aft_pkg::SF_WCACHE_OFF, aft_pkg::SF_APM_OFF,
                    aft_pkg::SF_PUIS_ON, aft_pkg::SF_PUIS_OFF, aft_pkg::SF_PUIS_SPINUP,
                    aft_pkg::SF_SECT_TIME, aft_pkg::SF_EPC, aft_pkg::SF_RLA_OFF,
                    aft_pkg::SF_RLA_ON, aft_pkg::SF_REVERT_OFF, aft_pkg::SF_REVERT_ON: abort = 1'b0;
                    aft_pkg::SF_XFER_MODE: abort = !xf_ok;
                    aft_pkg::SF_APM_ON: abort = !apm_ok;
                    aft_pkg::SF_LINK_ON, aft_pkg::SF_LINK_OFF: abort = !link_ok;
                    default: abort = 1'b1;
                endcase
            end
        end else begin
            // Other opcodes belong to other decoders; refused here
            abort = 1'b1;
        end
    end

    assign do_sf = state_r == AFT_EXEC && cmd_r == aft_pkg::CMD_SET_FEATURES && !abort;

    ////////////////////////////////////////////////////////////////////////
    // Feature settings
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wcache_en <= 1'b1;
            rla_en <= 1'b1;
            revert_en <= 1'b0;
            release_irq_en <= 1'b0;
            apm_en <= 1'b0;
            apm_level <= aft_pkg::APM_RESET;
            puis_en <= 1'b0;
            xfer_mode <= aft_pkg::XFER_RESET;
            iordy_off <= 1'b0;
            pio_sect_time <= 16'h0000;
            dma_sect_time <= 16'h0000;
            epc_arg <= 8'h00;
        end else if (do_sf) begin
            unique case (feat_r)
                aft_pkg::SF_WCACHE_ON: wcache_en <= 1'b1;
                aft_pkg::SF_WCACHE_OFF: wcache_en <= 1'b0;
                aft_pkg::SF_APM_ON: begin
                    apm_en <= 1'b1;
                    apm_level <= cnt_r;
                end
                aft_pkg::SF_APM_OFF: apm_en <= 1'b0;
                aft_pkg::SF_PUIS_ON: puis_en <= 1'b1;
                aft_pkg::SF_PUIS_OFF: puis_en <= 1'b0;
                aft_pkg::SF_XFER_MODE: begin
                    xfer_mode <= cnt_r;
                    iordy_off <= xf_type == aft_pkg::XF_PIO_DEFAULT
                        && xf_mode == aft_pkg::XF_PIO_DEF_IORDY_OFF;
                end
                aft_pkg::SF_SECT_TIME: begin
                    pio_sect_time <= {snum_r, cnt_r};
                    dma_sect_time <= {cyl_hi_r, cyl_lo_r};
                end
                aft_pkg::SF_EPC: epc_arg <= cnt_r;
                aft_pkg::SF_RLA_OFF: rla_en <= 1'b0;
                aft_pkg::SF_RLA_ON: rla_en <= 1'b1;
                aft_pkg::SF_REVERT_OFF: revert_en <= 1'b0;
                aft_pkg::SF_REVERT_ON: revert_en <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    // Link feature bits, one flop each
    genvar gi;
    generate
        for (gi = 0; gi < LINK_FEAT_W; gi++) begin : g_link
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    link_feat_en[gi] <= 1'b0;
                end else if (do_sf && cnt_r == 8'(gi)) begin
                    if (feat_r == aft_pkg::SF_LINK_ON) begin
                        link_feat_en[gi] <= 1'b1;
                    end else if (feat_r == aft_pkg::SF_LINK_OFF) begin
                        link_feat_en[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Standby and spin-up; standby is entered by the PUIS-on subcommand, and reset clears it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_standby <= 1'b0;
            spinup_req <= 1'b0;
            epc_req <= 1'b0;
        end else begin
            spinup_req <= do_sf && feat_r == aft_pkg::SF_PUIS_SPINUP && in_standby;
            epc_req <= do_sf && feat_r == aft_pkg::SF_EPC;
            if (do_sf && feat_r == aft_pkg::SF_PUIS_SPINUP) begin
                in_standby <= 1'b0;
            end else if (do_sf && feat_r == aft_pkg::SF_PUIS_ON) begin
                in_standby <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result and status; temperature sense never checks standby
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            command_error_flags <= aft_pkg::ERR_RESET;
            command_status_flags <= aft_pkg::STATUS_RESET;
            result_count <= aft_pkg::TEMP_RESET;
        end else begin
            unique case (state_r)
                AFT_IDLE: begin
                    if (cmd_wr) begin
                        command_status_flags <= 8'h80;
                        command_error_flags <= 8'h00;
                    end
                end
                AFT_EXEC: begin
                    command_status_flags <= 8'h80;
                    if (cmd_r == aft_pkg::CMD_TEMP_SENSE && !abort) begin
                        result_count <= temp_code;
                    end
                end
                AFT_DONE: begin
                    command_error_flags[aft_pkg::ERR_ABT] <= abort;
                    command_status_flags <= 8'h00;
                    command_status_flags[aft_pkg::ST_RDY] <= 1'b1;
                    command_status_flags[aft_pkg::ST_DSC] <= 1'b1;
                    command_status_flags[aft_pkg::ST_ERR] <= abort;
                end
                default: begin
                end
            endcase
        end
    end
endmodule : aft_cmd_decoder

// ==== rtl/aft_pkg.sv ====
// Purpose: Shared constants for the feature and temperature command decoder
// Assumes: Task-file registers arrive as plain byte ports
// Notes: Codes and fields only, no logic
package aft_pkg;
    localparam logic [7:0] CMD_TEMP_SENSE = 8'hf0;
    localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
    localparam logic [7:0] TEMP_FEATURE_OK = 8'h01;

    localparam logic [7:0] SF_WCACHE_ON = 8'h02;
    localparam logic [7:0] SF_XFER_MODE = 8'h03;
    localparam logic [7:0] SF_APM_ON = 8'h05;
    localparam logic [7:0] SF_PUIS_ON = 8'h06;
    localparam logic [7:0] SF_PUIS_SPINUP = 8'h07;
    localparam logic [7:0] SF_LINK_ON = 8'h10;
    localparam logic [7:0] SF_SECT_TIME = 8'h43;
    localparam logic [7:0] SF_EPC = 8'h4a;
    localparam logic [7:0] SF_RLA_OFF = 8'h55;
    localparam logic [7:0] SF_REVERT_OFF = 8'h66;
    localparam logic [7:0] SF_WCACHE_OFF = 8'h82;
    localparam logic [7:0] SF_APM_OFF = 8'h85;
    localparam logic [7:0] SF_PUIS_OFF = 8'h86;
    localparam logic [7:0] SF_LINK_OFF = 8'h90;
    localparam logic [7:0] SF_RLA_ON = 8'haa;
    localparam logic [7:0] SF_REVERT_ON = 8'hcc;

    // Transfer mode: type in [7:3], mode number in [2:0]
    localparam int XF_TYPE_LSB = 3;
    localparam logic [4:0] XF_PIO_DEFAULT = 5'h00;
    localparam logic [4:0] XF_PIO_FLOW = 5'h01;
    localparam logic [4:0] XF_MWDMA = 5'h04;
    localparam logic [4:0] XF_UDMA = 5'h08;
    localparam logic [2:0] XF_PIO_DEF_IORDY_OFF = 3'h1;
    localparam logic [2:0] XF_PIO_FLOW_MAX = 3'h4;
    localparam logic [2:0] XF_MWDMA_MAX = 3'h2;
    localparam logic [2:0] XF_UDMA_MAX = 3'h6;

    localparam logic [7:0] APM_ABORT_LO = 8'h00;
    localparam logic [7:0] APM_ABORT_HI = 8'hff;

    // Device/head bits that must be one for set-features
    localparam int DH_BIT7 = 7;
    localparam int DH_BIT5 = 5;

    // Error and status bit positions
    localparam int ERR_ABT = 2;
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_ERR = 0;

    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h50;
    localparam logic [7:0] XFER_RESET = 8'h00;
    localparam logic [7:0] APM_RESET = 8'h00;
    localparam logic [7:0] TEMP_RESET = 8'h00;
endpackage : aft_pkg

// ==== rtl/aft_temp_encode.sv ====
// Purpose: Encode a raw temperature into the result byte
// Assumes: Input in half degrees above -20 degC, signed
// Notes: Saturates at both ends
`timescale 1ns/10ps
module aft_temp_encode (
    input wire logic signed [10:0] temp_half_deg,
    output logic [7:0] code
);
    // Raw 1..254 maps straight, value/2 - 20 degC
    always_comb begin
        if (temp_half_deg <= 11'sd0) begin
            code = 8'h00;
        end else if (temp_half_deg >= 11'sd255) begin
            code = 8'hff;
        end else begin
            code = temp_half_deg[7:0];
        end
    end
endmodule : aft_temp_encode

// ==== testbench/aft_host_model.sv ====
// Purpose: Host side model that loads the task file and strobes a command
// Assumes: Driven off the falling edge, one command at a time
// Notes: Registers are inverted after the strobe to expose late sampling
`timescale 1ns/10ps
module aft_host_model (
    input wire logic sys_clk,
    output logic cmd_wr,
    output logic [7:0] cmd_code,
    output logic [7:0] feature,
    output logic [7:0] sector_count,
    output logic [7:0] sector_number,
    output logic [7:0] cyl_low,
    output logic [7:0] cyl_high,
    output logic [7:0] device_head
);
    initial begin
        cmd_wr = 1'b0;
        {cmd_code, feature, sector_count, sector_number, cyl_low, cyl_high, device_head} = '0;
    end
    ////////////////////////////////////////////////////////////////
    // Caller picks feature 01h for temperature and dev/head 7,5 for set-features
    task automatic send(input logic [7:0] c, f, n, d, sn, cl, ch);
        @(negedge sys_clk);
        {cmd_code, feature, sector_count, device_head} = {c, f, n, d};
        {sector_number, cyl_low, cyl_high} = {sn, cl, ch};
        cmd_wr = 1'b1;
        @(negedge sys_clk);
        cmd_wr = 1'b0;
        // Released lines show garbage, not the old value
        {cmd_code, feature, sector_count, sector_number, cyl_low, cyl_high, device_head} =
            ~{cmd_code, feature, sector_count, sector_number, cyl_low, cyl_high, device_head};
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : send
endmodule : aft_host_model

// ==== testbench/aft_cmd_decoder_chk.sv ====
// Purpose: Timing and result assertions for the command decoder
// Assumes: Sees only top-level ports
// Notes: Fixed three-edge command latency
`timescale 1ns/10ps
module aft_cmd_decoder_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] feature,
    input wire logic [7:0] sector_count,
    input wire logic [7:0] device_head,
    input wire logic signed [10:0] temp_half_deg,
    input wire logic [7:0] command_error_flags,
    input wire logic [7:0] command_status_flags,
    input wire logic [7:0] result_count,
    input wire logic wcache_en,
    input wire logic rla_en,
    input wire logic spinup_req,
    input wire logic [7:0] xfer_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire go = cmd_wr && !command_status_flags[7];
    wire sf = go && cmd_code == 8'hef && device_head[7] && device_head[5];
    ////////////////////////////////////////////////////////////////
    a_busy_window: assert property (go |=> command_status_flags == 8'h80 ##1
        command_status_flags == 8'h80 ##1 !command_status_flags[7]) else $error("busy window wrong");
    a_err_match: assert property (!command_status_flags[7] |->
        command_status_flags[0] == command_error_flags[2]) else $error("error bits disagree");
    a_temp_reject: assert property (go && cmd_code == 8'hf0 && feature != 8'h01 |->
        ##3 command_error_flags == 8'h04) else $error("bad temp feature not aborted");
    a_temp_floor: assert property (go && cmd_code == 8'hf0 && feature == 8'h01 && temp_half_deg <= 0 |->
        ##3 result_count == 8'h00) else $error("low temperature code wrong");
    a_undef_sub: assert property (sf && feature == 8'h00 |->
        ##3 command_status_flags == 8'h51) else $error("undefined subcode accepted");
    a_head_bits: assert property (go && cmd_code == 8'hef && !(device_head[7] && device_head[5]) |->
        ##3 command_error_flags[2]) else $error("dev head bits not checked");
    a_wcache_set: assert property (sf && feature == 8'h02 |-> ##3 wcache_en) else $error("cache not on");
    a_rla_clear: assert property (sf && feature == 8'h55 |-> ##3 !rla_en) else $error("look-ahead not off");
    a_spin_pulse: assert property ($rose(spinup_req) |=> !spinup_req) else $error("spin-up pulse long");
    a_udma_mode: assert property (sf && feature == 8'h03 && sector_count == 8'h46 |->
        ##3 xfer_mode == 8'h46) else $error("ultra mode not set");
endmodule : aft_cmd_decoder_chk
bind aft_cmd_decoder aft_cmd_decoder_chk u_chk (.sys_clk, .rst, .cmd_wr, .cmd_code, .feature, .sector_count,
    .device_head, .temp_half_deg, .command_error_flags, .command_status_flags, .result_count, .wcache_en,
    .rla_en, .spinup_req, .xfer_mode);

// ==== testbench/tb_aft_cmd_decoder.sv ====
// Purpose: Self-checking bench for the command decoder
// Assumes: Host model drives the task file
// Notes: Random temperatures and registers from a fixed seed
`timescale 1ns/10ps
module tb_aft_cmd_decoder;
    logic sys_clk, rst, cmd_wr, wcache_en, rla_en, revert_en, release_irq_en, apm_en, puis_en;
    logic in_standby, spinup_req, iordy_off, epc_req;
    logic [7:0] cmd_code, feature, sector_count, sector_number, cyl_low, cyl_high, device_head;
    logic [7:0] command_error_flags, command_status_flags, result_count, apm_level, xfer_mode, epc_arg;
    logic [7:0] link_feat_en, sn_v, cl_v, ch_v, f;
    logic [15:0] pio_sect_time, dma_sect_time;
    logic signed [10:0] temp_half_deg;
    int failures = 0, checked = 0, cycles = 0, seed = 90, t;
    int spin_n = 0, epc_n = 0;
    int corner [6] = '{-5, 0, 1, 254, 255, 400};
    logic [15:0] sub [11] = '{16'h0200, 16'h8200, 16'h5500, 16'haa00, 16'hcc00, 16'h6600, 16'h0200,
        16'h0580, 16'h8500, 16'h0600, 16'h8600};
    logic [5:0] exp6 [11] = '{6'h30, 6'h10, 6'h00, 6'h10, 6'h18, 6'h10, 6'h30, 6'h34, 6'h30, 6'h33, 6'h31};
    aft_host_model host (.sys_clk, .cmd_wr, .cmd_code, .feature, .sector_count, .sector_number, .cyl_low,
        .cyl_high, .device_head);
    aft_cmd_decoder #(.LINK_FEAT_W(8)) uut (.sys_clk, .rst, .cmd_wr, .cmd_code, .feature, .sector_count,
        .sector_number, .cyl_low, .cyl_high, .device_head, .temp_half_deg, .command_error_flags,
        .command_status_flags, .result_count, .wcache_en, .rla_en, .revert_en, .release_irq_en, .apm_en,
        .apm_level, .puis_en, .in_standby, .spinup_req, .link_feat_en, .xfer_mode, .iordy_off,
        .pio_sect_time, .dma_sect_time, .epc_req, .epc_arg);
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Pulses last one cycle, so count them while they stand
    always @(posedge sys_clk) begin
        if (spinup_req === 1'b1) spin_n++;
        if (epc_req === 1'b1) epc_n++;
    end
    // Hang guard, well above the expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] enc(input int v);
        return (v <= 0) ? 8'h00 : (v >= 255) ? 8'hff : 8'(v);
    endfunction : enc
    function automatic logic xf_ok(input logic [7:0] n);
        case (n[7:3])
            5'h00: return n[2:0] <= 3'h1;
            5'h01: return n[2:0] <= 3'h4;
            5'h04: return n[2:0] <= 3'h2;
            5'h08: return n[2:0] <= 3'h6;
            default: return 1'b0;
        endcase
    endfunction : xf_ok
    function automatic logic defd(input logic [7:0] v);
        return v inside {8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h10, 8'h43, 8'h4a, 8'h55, 8'h66, 8'h82,
            8'h85, 8'h86, 8'h90, 8'haa, 8'hcc};
    endfunction : defd
    task automatic check(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] c, fe, n, d, input logic ab);
        {sn_v, cl_v, ch_v} = 24'($random(seed));
        spin_n = 0;
        epc_n = 0;
        host.send(c, fe, n, d, sn_v, cl_v, ch_v);
        check(command_status_flags, ab ? 8'h51 : 8'h50);
        check(command_error_flags, ab ? 8'h04 : 8'h00);
    endtask : cmd
    task automatic complete_run();
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        temp_half_deg = '0;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        check({command_status_flags, command_error_flags, result_count}, 24'h500000);
        check({wcache_en, rla_en, revert_en, release_irq_en, apm_en}, 5'b11000);
        for (int i = 0; i < 20; i++) begin
            t = (i < 6) ? corner[i] : $random(seed) % 300;
            temp_half_deg = 11'(t);
            cmd(8'hf0, 8'h01, 8'h00, 8'he0, 1'b0);
            check(result_count, enc(t));
            f = 8'($random(seed));
            cmd(8'hf0, (f == 8'h01) ? 8'h02 : f, 8'h00, 8'he0, 1'b1);
        end
        for (int i = 0; i < 11; i++) begin
            cmd(8'hef, sub[i][15:8], sub[i][7:0], 8'he0, 1'b0);
            check({wcache_en, rla_en, revert_en, apm_en, puis_en, in_standby}, exp6[i]);
        end
        cmd(8'hef, 8'h06, 8'h00, 8'ha0, 1'b0);
        // A fresh temperature, so a stale result cannot pass in standby
        temp_half_deg = 11'sd100;
        cmd(8'hf0, 8'h01, 8'h00, 8'he0, 1'b0);
        check({in_standby, result_count}, 9'h164);
        cmd(8'hef, 8'h07, 8'h00, 8'he0, 1'b0);
        check(spin_n, 32'h1);
        check(in_standby, 1'b0);
        check(apm_level, 8'h80);
        cmd(8'hef, 8'h05, 8'h00, 8'he0, 1'b1);
        cmd(8'hef, 8'h05, 8'hff, 8'he0, 1'b1);
        cmd(8'hef, 8'h10, 8'h03, 8'he0, 1'b0);
        check(link_feat_en[3], 1'b1);
        cmd(8'hef, 8'h90, 8'h03, 8'he0, 1'b0);
        check(link_feat_en[3], 1'b0);
        cmd(8'hef, 8'h10, 8'h00, 8'he0, 1'b1);
        cmd(8'hef, 8'h43, 8'h5a, 8'he0, 1'b0);
        check({pio_sect_time, dma_sect_time}, {sn_v, 8'h5a, ch_v, cl_v});
        cmd(8'hef, 8'h4a, 8'h3c, 8'he0, 1'b0);
        check(epc_n, 32'h1);
        check(epc_arg, 8'h3c);
        for (int i = 0; i < 20; i++) begin
            f = 8'h00;
            if (i > 0) do f = 8'($random(seed)); while (defd(f));
            cmd(8'hef, f, 8'h00, 8'he0, 1'b1);
        end
        cmd(8'hef, 8'h02, 8'h00, 8'h60, 1'b1);
        cmd(8'hef, 8'h02, 8'h00, 8'hc0, 1'b1);
        cmd(8'h00, 8'h01, 8'h00, 8'he0, 1'b1);
        for (int i = 0; i < 256; i++) begin
            cmd(8'hef, 8'h03, 8'(i), 8'he0, !xf_ok(8'(i)));
            if (xf_ok(8'(i))) check(xfer_mode, 8'(i));
        end
        cmd(8'hef, 8'h03, 8'h01, 8'he0, 1'b0);
        check(iordy_off, 1'b1);
        cmd(8'hef, 8'h03, 8'h00, 8'he0, 1'b0);
        check(iordy_off, 1'b0);
        complete_run();
    end
endmodule : tb_aft_cmd_decoder
